// File: design/des_alu_catch.sv
`timescale 1ns/1ps
module des_alu_catch (
	input wire logic ref_clk,
	input wire logic arst_n,
	des_alu_if.alu alu
);
	logic [15:0] aluOut;
	logic [15:0] catch_q;
	// subtract is a plus inverted b plus carry, add is a plus b plus carry
	always_comb begin
		if (alu.subSel) begin
			aluOut = 16'(alu.opA + ~alu.opB + {15'h0000, alu.carryIn});
		end else begin
			aluOut = 16'(alu.opA + alu.opB + {15'h0000, alu.carryIn});
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			catch_q <= des_pkg::RESET_WORD;
		end else if (alu.catchStrobe) begin
			catch_q <= aluOut;
		end
	end
	assign alu.catchQ = catch_q;
endmodule : des_alu_catch

// File: design/des_alu_if.sv
`timescale 1ns/1ps
interface des_alu_if;
	logic [15:0] opA;
	logic [15:0] opB;
	logic subSel;
	logic carryIn;
	logic catchStrobe;
	logic [15:0] catchQ;
	modport seq (output opA, output opB, output subSel, output carryIn, output catchStrobe,
		input catchQ);
	modport alu (input opA, input opB, input subSel, input carryIn, input catchStrobe,
		output catchQ);
endinterface : des_alu_if

// File: design/des_director_exec_sequencer.sv
`timescale 1ns/1ps
// Function
// - branch stages A, B, C set on successive clocks, held by request or write timing
// - with wait-for-read captured, stage A waits until read-in-progress drops
// - at stage B, condition met disables write timing and steers branch address
// - at stage C, condition met loads address, flushes buffer, requests a director
// - at stage C, condition not met with erase enable turns on erase head
// - next clock clears B, ends branch, presets request, signals completion; then clears C
// - condition met also sets decode enable at completion
// - terminate code preclears ready, later clears execution enable
// - after terminate no branch or arithmetic director executes until resume function code 0022 arrives
// - code 10 subtracts operand from addressed register word, writes back
// - code 12 adds operand to addressed register word, writes back
// - bits 28-31 load register address; register word is A, operand is B
// - subtract selects subtract function with carry in
// - add selects add function lines without carry in
// - alu timing chain advances one step per clock, CLK1 to CLK8
// - CLK5 strobes alu output into catching register
// - CLK6 drives catch onto register bus and clears operation state
// - CLK7 writes both register halves and sets director done
// - CLK8 clears last stage and precleared done; clear state self clears
// - code 14 test director, handled outside this block
// - branch condition is any selected flag set
// - erase enable sets only with bit 15 captured and read-in-progress high
module des_director_exec_sequencer (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [31:0] directorWord,
	input wire logic functionDirectorDecode,
	input wire logic partialDecodeEnable,
	input wire logic directorExecuteStrobe,
	input wire logic directorReadoutStrobe,
	input wire logic directorFetchRequest,
	input wire logic directorStoreTiming,
	input wire logic directorStoreTimingAlt,
	input wire logic readInProgress,
	input wire logic flagEqual,
	input wire logic flagPositive,
	input wire logic flagNegative,
	input wire logic flagCompareNotMet,
	input wire logic flagCheckwordNonzero,
	input wire logic flagBitCompare,
	input wire logic hostFuncValid,
	input wire logic [15:0] hostFuncCode,
	input wire logic [15:0] regfileReadData,
	output logic [15:0] branchAddress,
	output logic disableDirectorWrite,
	output logic branchAddrToMemMux,
	output logic branchAddressLoad,
	output logic loadDirectorAddress,
	output logic branchFlush,
	output logic eraseHeadOn,
	output logic branchFinish,
	output logic branchMadeDecodeEnable,
	output logic supportRequestPreset,
	output logic supportReadyPreclear,
	output logic directorExecEnable,
	output logic loadRegfileAddress,
	output logic [3:0] regfileAddress,
	output logic aluCarryIn,
	output logic aluFuncSel0,
	output logic aluFuncSel1,
	output logic aluFuncSel3,
	output logic aluToCatchEnable,
	output logic catchResultStrobe,
	output logic catchToRegfileBus,
	output logic regfileMemoryEnable,
	output logic aluRegfileWrite,
	output logic regfileWriteLow,
	output logic regfileWriteHigh,
	output logic aluSequenceDone,
	output logic directorDone,
	output logic [15:0] regfileBus
);
	// ==========================================================
	// decode
	logic [7:0] code;
	logic decodeOk;
	logic startBranch;
	logic startTerm;
	logic startArith;
	logic isSub;
	logic branchHold;
	logic condMet;
	des_pkg::des_aop_t aop_q;
	logic [3:0] aluStep_q;
	assign code = directorWord[31:24];
	// no branch or arithmetic director starts while execution is disabled; terminate still decodes
	assign decodeOk = functionDirectorDecode & partialDecodeEnable & directorExecuteStrobe
		& directorExecEnable;
	assign startBranch = decodeOk & (code == des_pkg::CODE_BRANCH);
	assign startTerm = directorReadoutStrobe & (code == des_pkg::CODE_TERM);
	assign isSub = code == des_pkg::CODE_SUB;
	assign startArith = decodeOk & (isSub | (code == des_pkg::CODE_ADD)) & (aluStep_q == 4'h0)
		& (aop_q == des_pkg::AOP_IDLE);
	assign branchHold = directorFetchRequest | directorStoreTiming | directorStoreTimingAlt;
	// ==========================================================
	// branch chain
	logic branchActive_q;
	logic waitRead_q;
	logic eraseEnable_q;
	logic [6:0] flagSel_q;
	logic stageA_q;
	logic stageB_q;
	logic stageC_q;
	logic [15:0] branchAddr_q;
	assign condMet = |(flagSel_q & {flagEqual, flagPositive, flagNegative, 1'b0,
		flagCompareNotMet, flagCheckwordNonzero, flagBitCompare});
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			waitRead_q <= 1'b0;
			eraseEnable_q <= 1'b0;
			flagSel_q <= 7'h00;
			branchAddr_q <= des_pkg::RESET_WORD;
		end else if (startBranch) begin
			waitRead_q <= directorWord[des_pkg::WAIT_RD_POS];
			eraseEnable_q <= directorWord[des_pkg::WAIT_RD_POS] & readInProgress;
			flagSel_q <= directorWord[des_pkg::FLAG_EQ_POS -: 7];
			branchAddr_q <= directorWord[des_pkg::BRA_MSB:des_pkg::BRA_LSB];
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			branchActive_q <= 1'b0;
			stageA_q <= 1'b0;
			stageB_q <= 1'b0;
			stageC_q <= 1'b0;
		end else begin
			if (startBranch) begin
				branchActive_q <= 1'b1;
			end else if (stageB_q & stageC_q & !branchHold) begin
				// preclear branch state, only together with clearing B
				branchActive_q <= 1'b0;
			end
			if (branchActive_q & !branchHold) begin
				if (!stageA_q & !stageB_q & !stageC_q & !(waitRead_q & readInProgress)) begin
					stageA_q <= 1'b1;
				end else if (stageA_q & !stageB_q) begin
					stageB_q <= 1'b1;
				end else if (stageA_q & stageB_q) begin
					stageC_q <= 1'b1;
					stageA_q <= 1'b0;
				end else if (stageB_q & stageC_q) begin
					stageB_q <= 1'b0;
				end
			end else if (!branchActive_q & stageC_q) begin
				stageC_q <= 1'b0;
			end
		end
	end
	logic atB;
	logic atC;
	logic atFinish;
	assign atB = branchActive_q & !branchHold & stageA_q & !stageB_q;
	assign atC = branchActive_q & !branchHold & stageA_q & stageB_q;
	assign atFinish = branchActive_q & !branchHold & stageB_q & stageC_q;
	// ==========================================================
	// branch outputs
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			disableDirectorWrite <= 1'b0;
			branchAddrToMemMux <= 1'b0;
		end else begin
			if (atB & condMet) begin
				disableDirectorWrite <= 1'b1;
				branchAddrToMemMux <= 1'b1;
			end else if (atFinish) begin
				disableDirectorWrite <= 1'b0;
				branchAddrToMemMux <= 1'b0;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			branchAddressLoad <= 1'b0;
			loadDirectorAddress <= 1'b0;
			branchFlush <= 1'b0;
			eraseHeadOn <= 1'b0;
			branchFinish <= 1'b0;
			branchMadeDecodeEnable <= 1'b0;
		end else begin
			branchAddressLoad <= atC & condMet;
			loadDirectorAddress <= atC & condMet;
			branchFlush <= atC & condMet;
			eraseHeadOn <= atC & !condMet & eraseEnable_q;
			branchFinish <= atFinish;
			branchMadeDecodeEnable <= atFinish & condMet;
		end
	end
	assign branchAddress = branchAddr_q;
	assign supportRequestPreset = branchFinish;
	// ==========================================================
	// terminate
	logic [1:0] termCnt_q;
	logic termPend_q;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			termPend_q <= 1'b0;
			termCnt_q <= 2'h0;
			supportReadyPreclear <= 1'b0;
			directorExecEnable <= 1'b1;
		end else begin
			supportReadyPreclear <= startTerm;
			if (startTerm) begin
				termPend_q <= 1'b1;
				termCnt_q <= des_pkg::TERM_DELAY;
			end else if (termPend_q & termCnt_q != 2'h0) begin
				termCnt_q <= termCnt_q - 2'h1;
			end else if (termPend_q) begin
				termPend_q <= 1'b0;
				directorExecEnable <= 1'b0;
			end
			if (hostFuncValid & hostFuncCode == des_pkg::RESUME_FUNC & !termPend_q) begin
				directorExecEnable <= 1'b1;
			end
		end
	end
	// ==========================================================
	// arithmetic
	logic [15:0] operand_q;
	logic [3:0] rfAddr_q;
	des_alu_if aluIf ();
	des_alu_catch uCatch (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.alu(aluIf.alu)
	);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			operand_q <= des_pkg::RESET_WORD;
			rfAddr_q <= 4'h0;
		end else if (startArith) begin
			rfAddr_q <= directorWord[des_pkg::RFA_MSB:des_pkg::RFA_LSB];
			operand_q <= directorWord[des_pkg::OPER_MSB:des_pkg::OPER_LSB];
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			aop_q <= des_pkg::AOP_IDLE;
		end else begin
			case (aop_q)
				des_pkg::AOP_IDLE: begin
					if (startArith) begin
						aop_q <= isSub ? des_pkg::AOP_SUB : des_pkg::AOP_ADD;
					end
				end
				default: begin
					if (aluStep_q == des_pkg::STEP_BUS) begin
						aop_q <= des_pkg::AOP_IDLE;
					end
				end
			endcase
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			aluStep_q <= des_pkg::STEP_IDLE;
		end else begin
			if (startArith) begin
				aluStep_q <= 4'h1;
			end else if (aluStep_q == des_pkg::STEP_LAST) begin
				aluStep_q <= des_pkg::STEP_IDLE;
			end else if (aluStep_q != des_pkg::STEP_IDLE) begin
				aluStep_q <= aluStep_q + 4'h1;
			end
		end
	end
	logic doneClear_q;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			directorDone <= 1'b0;
			doneClear_q <= 1'b0;
		end else begin
			// done at CLK7, preclear at CLK8
			if (aluStep_q == des_pkg::STEP_WRITE) begin
				directorDone <= 1'b1;
				doneClear_q <= 1'b1;
			end else begin
				directorDone <= 1'b0;
				doneClear_q <= 1'b0;
			end
		end
	end
	logic opActive;
	assign opActive = aop_q != des_pkg::AOP_IDLE;
	assign aluCarryIn = aop_q == des_pkg::AOP_SUB;
	assign aluFuncSel1 = aop_q == des_pkg::AOP_SUB;
	assign aluFuncSel0 = aop_q == des_pkg::AOP_ADD;
	assign aluFuncSel3 = aop_q == des_pkg::AOP_ADD;
	assign aluToCatchEnable = opActive;
	assign aluIf.opA = regfileReadData;
	assign aluIf.opB = operand_q;
	assign aluIf.subSel = aluFuncSel1;
	assign aluIf.carryIn = aluCarryIn;
	assign catchResultStrobe = aluStep_q == des_pkg::STEP_CATCH;
	assign aluIf.catchStrobe = catchResultStrobe;
	assign catchToRegfileBus = aluStep_q == des_pkg::STEP_BUS;
	assign aluRegfileWrite = aluStep_q == des_pkg::STEP_WRITE;
	assign regfileWriteLow = aluRegfileWrite;
	assign regfileWriteHigh = aluRegfileWrite;
	assign aluSequenceDone = aluRegfileWrite;
	assign regfileMemoryEnable = !catchToRegfileBus;
	assign regfileBus = (catchToRegfileBus | aluRegfileWrite) ? aluIf.catchQ : regfileReadData;
	assign loadRegfileAddress = startArith;
	assign regfileAddress = rfAddr_q;
	// ==========================================================
	// assertions
	wait_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(waitRead_q & readInProgress & !stageA_q) |=> !stageA_q)
		else $error("stage A set while read in progress");
	steer_b_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(atB & condMet) |=> (stageB_q & branchAddrToMemMux & disableDirectorWrite))
		else $error("branch address not steered at stage B");
	flush_c_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(atC & condMet) |=> (stageC_q & branchFlush & loadDirectorAddress))
		else $error("branch not loaded at stage C");
	erase_on_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		eraseHeadOn |-> $past(!condMet & eraseEnable_q))
		else $error("erase head without enable");
	finish_seq_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		branchFinish |-> (!stageB_q & !branchActive_q & stageC_q) ##1 !stageC_q)
		else $error("branch completion order wrong");
	chain_step_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		startArith |=> aluStep_q == 4'h1 ##4 catchResultStrobe ##1 catchToRegfileBus
		##1 aluRegfileWrite ##1 aluStep_q == 4'h8 ##1 aluStep_q == 4'h0)
		else $error("alu chain out of step");
	done_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		aluRegfileWrite |=> directorDone ##1 !directorDone)
		else $error("director done timing wrong");
	sub_carry_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(startArith & isSub) |=> (aluCarryIn & aluFuncSel1 & !aluFuncSel0)[*6])
		else $error("subtract controls wrong");
	one_op_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(aluStep_q != 4'h0 && aluStep_q != 4'h8) |=> aluStep_q == $past(aluStep_q) + 4'h1)
		else $error("alu chain restarted");
endmodule : des_director_exec_sequencer

// File: design/des_pkg.sv
package des_pkg;
	// director codes (upper byte of the director word)
	localparam logic [7:0] CODE_BRANCH = 8'h04;
	localparam logic [7:0] CODE_TERM = 8'h08;
	localparam logic [7:0] CODE_SUB = 8'h10;
	localparam logic [7:0] CODE_ADD = 8'h12;
	localparam logic [7:0] CODE_TEST = 8'h14;
	// resume function code from the host channel
	localparam logic [15:0] RESUME_FUNC = 16'h0022;
	// field positions, bit 00 is the msb of a 32-bit director
	localparam int OPER_MSB = 31 - 8;
	localparam int OPER_LSB = 31 - 23;
	localparam int RFA_MSB = 31 - 28;
	localparam int RFA_LSB = 31 - 31;
	localparam int BRA_MSB = 31 - 16;
	localparam int BRA_LSB = 31 - 31;
	localparam int FLAG_EQ_POS = 31 - 8;
	localparam int FLAG_POSV_POS = 31 - 9;
	localparam int FLAG_NEG_POS = 31 - 10;
	localparam int FLAG_CMP_POS = 31 - 12;
	localparam int FLAG_CKW_POS = 31 - 13;
	localparam int FLAG_BIT_POS = 31 - 14;
	localparam int WAIT_RD_POS = 31 - 15;
	// alu timing chain length, CLK1..CLK8
	localparam int ALU_STEPS = 8;
	localparam logic [3:0] STEP_CATCH = 4'h5;
	localparam logic [3:0] STEP_BUS = 4'h6;
	localparam logic [3:0] STEP_WRITE = 4'h7;
	localparam logic [3:0] STEP_LAST = 4'h8;
	localparam logic [3:0] STEP_IDLE = 4'h0;
	// read time 300 as a delay after the terminate decode, in cycles
	localparam logic [1:0] TERM_DELAY = 2'h2;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	typedef enum logic [2:0] {
		AOP_IDLE = 3'b001,
		AOP_ADD = 3'b010,
		AOP_SUB = 3'b100
	} des_aop_t;
endpackage : des_pkg

// File: test/des_regfile_model.sv
`timescale 1ns/1ps
// ==========
// register file model, idles in read mode
module des_regfile_model (
	input wire logic ref_clk,
	input wire logic [3:0] regfileAddress,
	input wire logic [15:0] regfileBus,
	input wire logic regfileWriteLow,
	input wire logic regfileWriteHigh,
	output logic [15:0] regfileReadData
);
	logic [15:0] mem [16];
	// same seed pattern as the bench shadow copy
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = 16'h1357 * i[15:0];
		end
	end
	assign regfileReadData = mem[regfileAddress];
	always @(posedge ref_clk) begin
		if (regfileWriteLow) begin
			mem[regfileAddress][7:0] <= regfileBus[7:0];
		end
		if (regfileWriteHigh) begin
			mem[regfileAddress][15:8] <= regfileBus[15:8];
		end
	end
endmodule : des_regfile_model

// File: test/tb_top.sv
`timescale 1ns/1ps
// ==========
// bench top
module tb_top;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [31:0] directorWord;
	logic functionDirectorDecode, partialDecodeEnable, directorExecuteStrobe;
	logic directorReadoutStrobe, directorFetchRequest, directorStoreTiming;
	logic directorStoreTimingAlt, readInProgress, hostFuncValid;
	logic flagEqual, flagPositive, flagNegative, flagCompareNotMet;
	logic flagCheckwordNonzero, flagBitCompare;
	logic [15:0] hostFuncCode, regfileReadData, branchAddress, regfileBus;
	logic loadDirectorAddress, eraseHeadOn, branchFinish, branchMadeDecodeEnable;
	logic supportReadyPreclear, directorExecEnable, aluCarryIn, aluFuncSel0;
	logic aluFuncSel1, aluFuncSel3, catchResultStrobe, regfileWriteLow;
	logic regfileWriteHigh, aluRegfileWrite, directorDone;
	logic [3:0] regfileAddress;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	int seed = 7475;
	logic [15:0] expQ [$];
	logic [15:0] shadow [16];
	logic ldSeen = 1'b0;
	logic erSeen = 1'b0;

	always #2 ref_clk = ~ref_clk;

	des_director_exec_sequencer des_director_exec_sequencer_i (
		.ref_clk, .arst_n, .directorWord, .functionDirectorDecode, .partialDecodeEnable,
		.directorExecuteStrobe, .directorReadoutStrobe, .directorFetchRequest,
		.directorStoreTiming, .directorStoreTimingAlt, .readInProgress, .flagEqual,
		.flagPositive, .flagNegative, .flagCompareNotMet, .flagCheckwordNonzero,
		.flagBitCompare, .hostFuncValid, .hostFuncCode, .regfileReadData, .branchAddress,
		.disableDirectorWrite(), .branchAddrToMemMux(), .branchAddressLoad(),
		.loadDirectorAddress, .branchFlush(), .eraseHeadOn, .branchFinish,
		.branchMadeDecodeEnable, .supportRequestPreset(), .supportReadyPreclear,
		.directorExecEnable, .loadRegfileAddress(), .regfileAddress, .aluCarryIn,
		.aluFuncSel0, .aluFuncSel1, .aluFuncSel3, .aluToCatchEnable(), .catchResultStrobe,
		.catchToRegfileBus(), .regfileMemoryEnable(), .aluRegfileWrite, .regfileWriteLow,
		.regfileWriteHigh, .aluSequenceDone(), .directorDone, .regfileBus
	);

	des_regfile_model des_regfile_model_i (
		.ref_clk, .regfileAddress, .regfileBus, .regfileWriteLow, .regfileWriteHigh,
		.regfileReadData
	);

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [15:0] act, input logic [15:0] exp);
		cmp_count++;
		if (act !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, act, exp);
		end
	endtask : check

	// ==========
	// result watcher: oldest note against each result
	always @(negedge ref_clk) begin
		logic [15:0] act;
		if (loadDirectorAddress === 1'b1) begin
			ldSeen = 1'b1;
		end
		if (eraseHeadOn === 1'b1) begin
			erSeen = 1'b1;
		end
		if (catchResultStrobe === 1'b1) begin
			act = {12'h000, aluCarryIn, aluFuncSel1, aluFuncSel0, aluFuncSel3};
		end else if (aluRegfileWrite === 1'b1) begin
			act = (regfileWriteLow & regfileWriteHigh) ? regfileBus : 16'hBAD0;
		end else if (ldSeen) begin
			act = branchMadeDecodeEnable ? branchAddress : ~branchAddress;
		end else begin
			act = {14'h0000, branchMadeDecodeEnable, erSeen};
		end
		if (catchResultStrobe === 1'b1 || aluRegfileWrite === 1'b1 || branchFinish === 1'b1) begin
			// an empty queue means an unasked result
			check(act, (expQ.size() > 0) ? expQ.pop_front() : ~act);
			if (branchFinish === 1'b1) begin
				ldSeen = 1'b0;
				erSeen = 1'b0;
			end
		end
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic issue(input logic [31:0] w, input logic rd);
		@(posedge ref_clk);
		#1;
		directorWord = w;
		{functionDirectorDecode, partialDecodeEnable, directorExecuteStrobe} = {3{~rd}};
		directorReadoutStrobe = rd;
		@(posedge ref_clk);
		#1;
		{functionDirectorDecode, partialDecodeEnable, directorExecuteStrobe} = 3'h0;
		directorReadoutStrobe = 1'b0;
	endtask : issue

	task automatic wait_done(output int n);
		n = 0;
		while (branchFinish !== 1'b1 && directorDone !== 1'b1 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
	endtask : wait_done

	task automatic branch(input logic [6:0] sel, input logic [5:0] fl, input logic wt,
		input logic rp, input logic [2:0] hv, input int hn);
		logic met;
		logic [15:0] ba;
		int n;
		ba = $random(seed);
		met = |({sel[6:4], sel[2:0]} & fl);
		{flagEqual, flagPositive, flagNegative, flagCompareNotMet} = fl[5:2];
		{flagCheckwordNonzero, flagBitCompare} = fl[1:0];
		readInProgress = rp;
		expQ.push_back(met ? ba : {15'h0000, wt & rp & ~met});
		issue({8'h04, sel, wt, ba}, 1'b0);
		fork
			begin
				{directorFetchRequest, directorStoreTiming, directorStoreTimingAlt} = hv;
				repeat (hn) @(posedge ref_clk);
				#1;
				{directorFetchRequest, directorStoreTiming, directorStoreTimingAlt} = 3'h0;
				readInProgress = 1'b0;
			end
			wait_done(n);
		join
		check(n[15:0], 16'd5 + hn[15:0]);
	endtask : branch

	task automatic arith(input logic sub, input logic [3:0] a, input logic [15:0] op,
		input logic busy);
		logic [15:0] r;
		int n;
		r = sub ? shadow[a] - op : shadow[a] + op;
		expQ.push_back(sub ? 16'h000C : 16'h0003);
		expQ.push_back(r);
		shadow[a] = r;
		issue({sub ? des_pkg::CODE_SUB : des_pkg::CODE_ADD, op, 4'h0, a}, 1'b0);
		// a start while the chain runs must be ignored
		if (busy) begin
			issue({des_pkg::CODE_ADD, 16'h1111, 4'h0, a + 4'h1}, 1'b0);
		end
		wait_done(n);
		check(n[15:0], busy ? 16'd6 : 16'd8);
		@(negedge ref_clk);
		check({15'h0000, directorDone}, 16'h0000);
	endtask : arith

	// ==========
	// main sequence
	initial begin
		directorWord = 32'h0000_0000;
		{functionDirectorDecode, partialDecodeEnable, directorExecuteStrobe} = 3'h0;
		{directorReadoutStrobe, directorFetchRequest, directorStoreTiming} = 3'h0;
		{directorStoreTimingAlt, readInProgress, hostFuncValid} = 3'h0;
		{flagEqual, flagPositive, flagNegative, flagCompareNotMet} = 4'h0;
		{flagCheckwordNonzero, flagBitCompare} = 2'h0;
		hostFuncCode = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			shadow[i] = 16'h1357 * i[15:0];
		end
		repeat (16) @(posedge ref_clk);
		#1;
		arst_n = 1'b1;
		for (int j = 0; j < 7; j++) begin
			branch(7'h01 << j, 6'h3F, 1'b0, 1'b0, 3'h0, 0);
			branch(7'h01 << j, 6'($random(seed)), 1'b0, 1'b1, 3'h0, 0);
		end
		branch(7'h06, 6'h00, 1'b1, 1'b1, 3'h0, 4);
		branch(7'h06, 6'h02, 1'b1, 1'b1, 3'h0, 3);
		branch(7'h40, 6'h20, 1'b0, 1'b0, 3'h4, 2);
		branch(7'h01, 6'h00, 1'b0, 1'b0, 3'h3, 3);
		arith(1'b0, 4'hF, 16'hFFFF, 1'b0);
		arith(1'b1, 4'h0, 16'h0001, 1'b1);
		for (int k = 0; k < 8; k++) begin
			arith(k[0], 4'($random(seed)), 16'($random(seed)), k[1]);
		end
		issue({des_pkg::CODE_TERM, 24'h000000}, 1'b1);
		@(negedge ref_clk);
		check({15'h0000, supportReadyPreclear}, 16'h0001);
		repeat (2) @(negedge ref_clk);
		check({15'h0000, directorExecEnable}, 16'h0001);
		@(negedge ref_clk);
		check({15'h0000, directorExecEnable}, 16'h0000);
		@(posedge ref_clk);
		#1;
		hostFuncValid = 1'b1;
		hostFuncCode = 16'h0021;
		@(posedge ref_clk);
		#1;
		hostFuncCode = des_pkg::RESUME_FUNC;
		@(negedge ref_clk);
		check({15'h0000, directorExecEnable}, 16'h0000);
		@(posedge ref_clk);
		#1;
		hostFuncValid = 1'b0;
		@(negedge ref_clk);
		check({15'h0000, directorExecEnable}, 16'h0001);
		check(expQ.size(), 16'h0000);
		finish_test();
	end
endmodule : tb_top
